// ---- rtl/dsb_sram_map.vh ----
// Constants for the burst SRAM bus-cycle block
`ifndef DSB_SRAM_MAP_VH
`define DSB_SRAM_MAP_VH
`define DSB_DATA_W     36
`define DSB_ADDR_W     18
`define DSB_BURST_LEN  3'h4
`define DSB_BEAT_W     3
`define DSB_MEM_DEPTH  64
`define DSB_MEM_AW     6
`define DSB_BUF_DEPTH  2
`endif

// ---- rtl/dsb_sram_core.v ----
// Burst SRAM bus-cycle logic: load, linear burst, write capture, read launch, echo clocks
`timescale 1ns/1ps
`include "dsb_sram_map.vh"
module dsb_sram_core (
  input  wire                     clk,           // System clock, 40 MHz
  input  wire                     nrst,          // Async reset, active low
  input  wire                     inClkPos,      // True input clock pin
  input  wire                     inClkNeg,      // Complement input clock pin
  input  wire                     outClkPos,     // True output clock pin
  input  wire                     outClkNeg,     // Complement output clock pin
  input  wire                     load_strobe_n, // Load strobe, active low
  input  wire                     readNotWrite,  // Direction select, high = read
  input  wire [`DSB_ADDR_W-1:0]   sync_addr_in,  // Address pins
  input  wire [`DSB_DATA_W-1:0]   dataIn,        // Data pins, input side
  output reg  [`DSB_DATA_W-1:0]   dataOut,       // Data pins, output side
  output reg                      dataOe,        // Data pin drive enable
  output reg                      echo_ref_pos,  // True echo clock
  output reg                      echo_ref_neg   // Complement echo clock
);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RD   = 3'h2;
  localparam [2:0] ST_WR   = 3'h4;

  // Two-flop synchronisers for every pin
  // Bit 0 is a spare stage held at zero so pin bits keep their positions
  // The load strobe bit resets to its idle level, high, so that no false
  // load can be taken while the pipeline is still filling after reset
  reg [6:0]             syncA_q;
  reg [6:0]             syncB_q;
  reg [6:0]             prev_q;
  reg [`DSB_ADDR_W-1:0] addrA_q;
  reg [`DSB_ADDR_W-1:0] addrB_q;
  reg [`DSB_DATA_W-1:0] dinA_q;
  reg [`DSB_DATA_W-1:0] dinB_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA_q <= 7'h20;
      syncB_q <= 7'h20;
      prev_q  <= 7'h20;
      addrA_q <= {`DSB_ADDR_W{1'b0}};
      addrB_q <= {`DSB_ADDR_W{1'b0}};
      dinA_q  <= {`DSB_DATA_W{1'b0}};
      dinB_q  <= {`DSB_DATA_W{1'b0}};
    end else begin
      syncA_q <= {readNotWrite, load_strobe_n, outClkNeg, outClkPos, inClkNeg, inClkPos, 1'b0};
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
      addrA_q <= sync_addr_in;
      addrB_q <= addrA_q;
      dinA_q  <= dataIn;
      dinB_q  <= dinA_q;
    end
  end

  wire kRise   = syncB_q[1] & ~prev_q[1];
  wire knRise  = syncB_q[2] & ~prev_q[2];
  wire cRise   = syncB_q[3] & ~prev_q[3];
  wire cnRise  = syncB_q[4] & ~prev_q[4];
  wire ldN     = syncB_q[5];
  wire rdSel   = syncB_q[6];
  // Output clocks both held high select input-clock launch timing
  wire outTied = syncB_q[3] & syncB_q[4];
  wire launchPos = outTied ? kRise : cRise;
  wire launchNeg = outTied ? knRise : cnRise;

  // Bus-cycle state, beat count, burst address
  reg [2:0]             state_q, state_d;
  reg [`DSB_BEAT_W-1:0] beat_q, beat_d;
  reg [`DSB_ADDR_W-1:0] addr_q, addr_d;
  wire [1:0] lowNext = addr_q[1:0] + 2'h1;

  // Next-state logic; loads only on true input clock rises, a finished burst drops to idle without one
  always @* begin
    state_d = state_q;
    beat_d  = beat_q;
    addr_d  = addr_q;
    case (state_q)
      ST_IDLE: begin
        if (kRise && !ldN) begin
          state_d = rdSel ? ST_RD : ST_WR;
          addr_d  = addrB_q;
          beat_d  = 3'h0;
        end
      end
      ST_RD, ST_WR: begin
        if (beat_q == `DSB_BURST_LEN) begin
          beat_d = 3'h0;
          if (kRise) begin
            if (!ldN) begin
              state_d = rdSel ? ST_RD : ST_WR;
              addr_d  = addrB_q;
            end else begin
              state_d = ST_IDLE;
            end
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // A load is taken on a true clock rise while no burst is running.
  // The complement rise right after the load edge still belongs to the
  // load cycle; data moves only from the next true rise on, so one half
  // period is skipped after every load.
  wire loadNow = kRise && !ldN && (state_q == ST_IDLE || beat_q == `DSB_BURST_LEN);
  reg  skipHalf_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      skipHalf_q <= 1'b0;
    end else if (loadNow) begin
      skipHalf_q <= 1'b1;
    end else if (knRise) begin
      skipHalf_q <= 1'b0;
    end
  end

  // Write beats on both clock rises once the skipped half has passed
  wire wrBeat = (state_q == ST_WR) && (kRise || knRise) && !skipHalf_q
                && (beat_q != `DSB_BURST_LEN);
  wire rdFetch;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      beat_q  <= 3'h0;
      addr_q  <= {`DSB_ADDR_W{1'b0}};
    end else begin
      if (kRise || state_q == ST_IDLE || beat_q == `DSB_BURST_LEN) begin
        state_q <= state_d;
        addr_q  <= addr_d;
      end
      if (wrBeat || rdFetch) begin
        beat_q <= beat_q + 3'h1;
        addr_q <= {addr_q[`DSB_ADDR_W-1:2], lowNext};
      end else if (kRise || beat_q == `DSB_BURST_LEN) begin
        beat_q <= beat_d;
      end
    end
  end

  // Small backing array; upper address bits beyond it alias
  // Limitation: only the low address bits index it, to keep the area small
  reg [`DSB_DATA_W-1:0] mem [0:`DSB_MEM_DEPTH-1];
  always @(posedge clk) begin
    if (wrBeat) begin
      mem[addr_q[`DSB_MEM_AW-1:0]] <= dinB_q;
    end
  end

  // Two-entry buffer between array read and pin launch
  reg [`DSB_DATA_W-1:0] buf_q [0:`DSB_BUF_DEPTH-1];
  reg       wrPtr_q, rdPtr_q;
  reg [1:0] count_q;
  wire bufFull  = (count_q == 2'h2);
  wire bufEmpty = (count_q == 2'h0);
  wire launch   = (launchPos || launchNeg) && !bufEmpty;
  // Fetch stalls when buffer full, so no word is lost
  // Fetch also waits out the skipped half, so the first word leaves on a
  // true clock rise and a word left from an earlier burst still goes first
  assign rdFetch = (state_q == ST_RD) && !bufFull && !skipHalf_q
                   && (beat_q != `DSB_BURST_LEN);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (rdFetch) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (launch) begin
        rdPtr_q <= ~rdPtr_q;
      end
      count_q <= count_q + {1'b0, rdFetch} - {1'b0, launch};
    end
  end
  always @(posedge clk) begin
    if (rdFetch) begin
      buf_q[wrPtr_q] <= mem[addr_q[`DSB_MEM_AW-1:0]];
    end
  end

  // Pin launch and echo clocks; echo rises with each word
  // Drive drops only on a launch edge, so a word never stands short
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataOut      <= {`DSB_DATA_W{1'b0}};
      dataOe       <= 1'b0;
      echo_ref_pos <= 1'b0;
      echo_ref_neg <= 1'b0;
    end else begin
      if (launch) begin
        dataOut      <= buf_q[rdPtr_q];
        dataOe       <= 1'b1;
        echo_ref_pos <= launchPos;
        echo_ref_neg <= launchNeg;
      end else if (state_q != ST_RD && bufEmpty && (launchPos || launchNeg)) begin
        dataOe       <= 1'b0;
        echo_ref_pos <= 1'b0;
        echo_ref_neg <= 1'b0;
      end
    end
  end
endmodule // dsb_sram_core

// ---- dv/dsb_sram_properties.sv ----
// Port checker of the burst SRAM bus-cycle block
`timescale 1ns/1ps
module dsb_sram_properties (
  input wire clk,           // Clock
  input wire nrst,          // Reset
  input wire inClkPos,      // True input clock
  input wire inClkNeg,      // Complement input clock
  input wire load_strobe_n, // Load strobe
  input wire dataOe,        // Data drive
  input wire echo_ref_pos,  // True echo
  input wire echo_ref_neg   // Complement echo
);
  reg [2:0] beatCnt_q;
  reg [5:0] idleCnt_q;
  // Words of this burst; idle time saturates so it never wraps
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beatCnt_q <= 3'h0;
      idleCnt_q <= 6'h00;
    end else begin
      beatCnt_q <= !dataOe ? 3'h0 : beatCnt_q + ($rose(dataOe) || $changed(echo_ref_pos));
      idleCnt_q <= load_strobe_n ? idleCnt_q + (idleCnt_q != 6'h3F) : 6'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence posHeld; echo_ref_pos [*3]; endsequence
  sequence oeHeld; dataOe [*7]; endsequence
  echo_pair_a: assert property (dataOe |-> echo_ref_pos != echo_ref_neg)
    else $error("echo pair not one-hot");
  pos_launch_a: assert property ($rose(echo_ref_pos) |-> $past(inClkPos, 3))
    else $error("true word without true clock");
  neg_launch_a: assert property ($rose(echo_ref_neg) |-> $past(inClkNeg, 3))
    else $error("second word without complement clock");
  first_word_a: assert property ($rose(dataOe) |-> echo_ref_pos)
    else $error("burst not opened on true clock");
  burst_four_a: assert property ($fell(dataOe) |-> beatCnt_q == 3'h4)
    else $error("burst length not four");
  nop_release_a: assert property (idleCnt_q > 6'h27 |-> !dataOe)
    else $error("driving while idle");
  pos_hold_a: assert property ($rose(echo_ref_pos) |=> posHeld)
    else $error("word stood too short");
  oe_hold_a: assert property ($rose(dataOe) |=> oeHeld)
    else $error("burst cut short");
endmodule // dsb_sram_properties
bind dsb_sram_core dsb_sram_properties u_chk (
  .clk           (clk),
  .nrst          (nrst),
  .inClkPos      (inClkPos),
  .inClkNeg      (inClkNeg),
  .load_strobe_n (load_strobe_n),
  .dataOe        (dataOe),
  .echo_ref_pos  (echo_ref_pos),
  .echo_ref_neg  (echo_ref_neg)
);

// ---- dv/dsb_ctrl_model.sv ----
// Memory controller model: input clocks, load, address and write data
`timescale 1ns/1ps
`include "dsb_sram_map.vh"
module dsb_ctrl_model (
  input  wire                  clk,                  // System clock
  output wire                  inClkPos,             // True input clock
  output wire                  inClkNeg,             // Complement input clock
  output wire                  outClkPos,            // True output clock
  output wire                  outClkNeg,            // Complement output clock
  output reg                   load_strobe_n = 1'b1, // Load strobe
  output reg                   readNotWrite = 1'b0,  // Direction
  output reg [`DSB_ADDR_W-1:0] sync_addr_in = 18'h0, // Address
  output reg [`DSB_DATA_W-1:0] wData = 36'h0        // Write data
);
  reg [2:0] phase = 3'h0;
  // Free running clock pair, eight system cycles a period
  always @(posedge clk) phase <= phase + 3'h1;
  assign inClkPos = !phase[2];
  assign inClkNeg = phase[2];
  // Output clocks tied high and never toggled
  assign outClkPos = 1'b1;
  assign outClkNeg = 1'b1;
  // Park just before a complement rise so the next beat leads a true rise
  task align;
    begin
      @(negedge clk);
      while (phase != 3'h2) @(negedge clk);
    end
  endtask
  // One half period of bus activity, set shortly after a clock edge
  task beat(input ld, input rw, input [`DSB_ADDR_W-1:0] a, input [`DSB_DATA_W-1:0] d);
    begin
      @(negedge clk);
      while (phase[1:0] != 2'h1) @(negedge clk);
      load_strobe_n = ld;
      readNotWrite = rw;
      sync_addr_in = a;
      wData = d;
    end
  endtask
endmodule // dsb_ctrl_model

// ---- dv/dsb_sram_core_bench.sv ----
// Testbench of the burst SRAM bus-cycle block
`timescale 1ns/1ps
`include "dsb_sram_map.vh"
module dsb_sram_core_bench;
  reg                    clk = 1'b0;
  reg                    nrst = 1'b0;
  wire                   inClkPos, inClkNeg, outClkPos, outClkNeg, load_strobe_n, readNotWrite;
  wire                   dataOe, echo_ref_pos, echo_ref_neg;
  wire [`DSB_ADDR_W-1:0] sync_addr_in;
  wire [`DSB_DATA_W-1:0] wData, dataIn, dataOut;
  integer                num_errors = 0;
  integer                samples_checked = 0;
  integer                cycles = 0;
  // Shared data pins: the device wins while it drives
  assign dataIn = dataOe ? dataOut : wData;
  initial forever #12.5 clk = ~clk;
  dsb_ctrl_model u_ctrl (
    .clk           (clk),
    .inClkPos      (inClkPos),
    .inClkNeg      (inClkNeg),
    .outClkPos     (outClkPos),
    .outClkNeg     (outClkNeg),
    .load_strobe_n (load_strobe_n),
    .readNotWrite  (readNotWrite),
    .sync_addr_in  (sync_addr_in),
    .wData         (wData)
  );
  dsb_sram_core u_dut (
    .clk           (clk),
    .nrst          (nrst),
    .inClkPos      (inClkPos),
    .inClkNeg      (inClkNeg),
    .outClkPos     (outClkPos),
    .outClkNeg     (outClkNeg),
    .load_strobe_n (load_strobe_n),
    .readNotWrite  (readNotWrite),
    .sync_addr_in  (sync_addr_in),
    .dataIn        (dataIn),
    .dataOut       (dataOut),
    .dataOe        (dataOe),
    .echo_ref_pos  (echo_ref_pos),
    .echo_ref_neg  (echo_ref_neg)
  );
  task check(input [63:0] name, input [`DSB_DATA_W-1:0] exp, got);
    begin
      samples_checked = samples_checked + 1;
      if (exp !== got) begin
        num_errors = num_errors + 1;
        $display("wrong value %0s exp %h got %h", name, exp, got);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // Write at XX10, junk address and direction while the burst runs
  task write_burst;
    integer i;
    begin
      u_ctrl.align;
      u_ctrl.beat(1'b0, 1'b0, 18'h0002E, 36'h0);
      u_ctrl.beat(1'b1, 1'b1, 18'h3FFD1, ~36'h0);
      for (i = 0; i < 4; i = i + 1)
        u_ctrl.beat(1'b1, 1'b1, 18'h3FFD1, 36'hA5A5A5A50 + i);
    end
  endtask
  // Back-to-back read from XX11: words wrap through the block
  task read_burst;
    integer i;
    begin
      u_ctrl.align;
      u_ctrl.beat(1'b0, 1'b1, 18'h0002F, 36'h0);
      for (i = 0; i < 7; i = i + 1) begin
        u_ctrl.beat(1'b1, 1'b0, 18'h3FFD0, ~36'h0);
        if (i > 2) begin
          check("word", 36'hA5A5A5A50 + ((i - 2) % 4), dataOut);
          check("echo", {33'h0, 1'b1, i[0], !i[0]}, {dataOe, echo_ref_pos, echo_ref_neg});
        end
      end
    end
  endtask
  // Strobe high: nothing starts and the pins stay released
  task idle_quiet;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        u_ctrl.beat(1'b1, i[0], 18'h0002C + i, ~36'h0);
        check("idle oe", {35'h0, dataOe}, 36'h0);
      end
    end
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    check("rst oe", {35'h0, dataOe}, 36'h0);
    write_burst;
    read_burst;
    idle_quiet;
    end_of_test;
  end
endmodule // dsb_sram_core_bench
